// *** logic/prioritised_vectored_interrupt_unit.sv ***
// vectored interrupt unit with priority levels and an AXI4-Lite register slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module prioritised_vectored_interrupt_unit
   import irq_unit_pkg::*;
(
   // clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rstn,
   // peripheral requests and reset entry
   input  wire logic [NUM_SRC-1:0] i_irq_req,
   input  wire logic               i_hw_reset_source,
   // cpu side
   input  wire logic               i_call_ack,
   input  wire logic               i_return_from_isr,
   output logic                    o_long_call,
   output logic [15:0]             o_vector_addr,
   output logic                    o_global_irq_enable,
   // axi4-lite write channels
   input  wire logic               i_s_axi_awvalid,
   output logic                    o_s_axi_awready,
   input  wire logic [11:0]        i_s_axi_awaddr,
   input  wire logic               i_s_axi_wvalid,
   output logic                    o_s_axi_wready,
   input  wire logic [31:0]        i_s_axi_wdata,
   input  wire logic [3:0]         i_s_axi_wstrb,
   output logic                    o_s_axi_bvalid,
   input  wire logic               i_s_axi_bready,
   output logic [1:0]              o_s_axi_bresp,
   // axi4-lite read channels
   input  wire logic               i_s_axi_arvalid,
   output logic                    o_s_axi_arready,
   input  wire logic [11:0]        i_s_axi_araddr,
   output logic                    o_s_axi_rvalid,
   input  wire logic               i_s_axi_rready,
   output logic [31:0]             o_s_axi_rdata,
   output logic [1:0]              o_s_axi_rresp,
   // summary interrupt
   output logic                    o_irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic addr_is(input logic [11:0] addr, input logic [7:0] idx);
      return addr == {2'h0, idx, 2'h0};
   endfunction

   function automatic logic [13:0] merge14(input logic [13:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [13:0] res;
      res = old;
      if (strb[0]) res[7:0] = data[7:0];
      if (strb[1]) res[13:8] = data[13:8];
      return res;
   endfunction

   // highest level currently in service, one-hot
   function automatic logic [3:0] top_bit(input logic [3:0] map);
      logic [3:0] res;
      res = 4'h0;
      for (int l = 0; l < NUM_LVL; l++) begin
         if (map[l]) res = 4'(1 << l);
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic                aw_full_ff;
   logic [11:0]         aw_addr_ff;
   logic                w_full_ff;
   logic [31:0]         w_data_ff;
   logic [3:0]          w_strb_ff;
   logic                awready_ff;
   logic                wready_ff;
   logic                bvalid_ff;
   logic [1:0]          bresp_ff;
   logic                arready_ff;
   logic                rvalid_ff;
   logic [31:0]         rdata_ff;
   logic [1:0]          rresp_ff;

   logic                ge_ff;
   logic [5:0]          en0_ff;
   logic [5:0]          en1_ff;
   logic [1:0]          en2_ff;
   logic [5:0]          prio_low_ff;
   logic [5:0]          prio_high_ff;
   logic [13:0]         edge_sel_ff;
   logic [13:0]         status_ff;
   logic [13:0]         mask_ff;
   logic                irq_ff;

   logic                rst_meta_ff;
   logic                rst_sync_ff;
   logic                rst_prev_ff;
   logic                rst_pend_ff;

   vec_state_type       state_ff;
   vec_state_type       nxt_state;
   logic [2:0]          wait_cnt_ff;
   logic [2:0]          nxt_wait_cnt;
   logic [3:0]          cur_src_ff;
   logic [3:0]          nxt_cur_src;
   logic [1:0]          cur_lvl_ff;
   logic [1:0]          nxt_cur_lvl;
   logic                cur_rst_ff;
   logic                nxt_cur_rst;
   logic [3:0]          in_service_ff;
   logic                call_ff;
   logic [15:0]         vector_ff;

   irq_pend_if          pend ();

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire logic aw_take   = i_s_axi_awvalid & awready_ff;
   wire logic w_take    = i_s_axi_wvalid & wready_ff;
   wire logic wr_fire   = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire logic ar_take   = i_s_axi_arvalid & arready_ff;
   wire logic r_done    = rvalid_ff & i_s_axi_rready;
   wire logic b_done    = bvalid_ff & i_s_axi_bready;
   wire logic lane0     = w_strb_ff[0];

   wire logic hit_en0   = addr_is(aw_addr_ff, IDX_EN0);
   wire logic hit_en1   = addr_is(aw_addr_ff, IDX_EN1);
   wire logic hit_en2   = addr_is(aw_addr_ff, IDX_EN2);
   wire logic hit_plow  = addr_is(aw_addr_ff, IDX_PRIO_LOW);
   wire logic hit_phigh = addr_is(aw_addr_ff, IDX_PRIO_HIGH);
   wire logic hit_edge  = addr_is(aw_addr_ff, IDX_EDGE_SEL);
   wire logic hit_mask  = addr_is(aw_addr_ff, IDX_MASK);
   wire logic hit_ro    = addr_is(aw_addr_ff, IDX_STATUS)
                        | addr_is(aw_addr_ff, IDX_PENDING)
                        | addr_is(aw_addr_ff, IDX_STATE);
   wire logic wr_known  = hit_en0 | hit_en1 | hit_en2 | hit_plow | hit_phigh
                        | hit_edge | hit_mask | hit_ro;

   wire logic wr_en0    = wr_fire & hit_en0 & lane0;
   wire logic wr_en1    = wr_fire & hit_en1 & lane0;
   wire logic wr_en2    = wr_fire & hit_en2 & lane0;
   wire logic wr_plow   = wr_fire & hit_plow & lane0;
   wire logic wr_phigh  = wr_fire & hit_phigh & lane0;
   wire logic wr_edge   = wr_fire & hit_edge;
   wire logic wr_mask   = wr_fire & hit_mask;

   wire logic [11:0] ra = i_s_axi_araddr;
   wire logic rd_known  = addr_is(ra, IDX_EN0) | addr_is(ra, IDX_EN1)
                        | addr_is(ra, IDX_EN2) | addr_is(ra, IDX_PRIO_LOW)
                        | addr_is(ra, IDX_PRIO_HIGH) | addr_is(ra, IDX_EDGE_SEL)
                        | addr_is(ra, IDX_STATUS) | addr_is(ra, IDX_MASK)
                        | addr_is(ra, IDX_PENDING) | addr_is(ra, IDX_STATE);
   // reading status clears it, so only an accepted read may do so
   wire logic status_rd_clr = ar_take & addr_is(ra, IDX_STATUS);

   // bit 6 of enable register 0 is unimplemented and reads zero
   wire logic [31:0] rd_data =
        addr_is(ra, IDX_EN0)       ? {24'h0, ge_ff, 1'h0, en0_ff}
      : addr_is(ra, IDX_EN1)       ? {26'h0, en1_ff}
      : addr_is(ra, IDX_EN2)       ? {30'h0, en2_ff}
      : addr_is(ra, IDX_PRIO_LOW)  ? {26'h0, prio_low_ff}
      : addr_is(ra, IDX_PRIO_HIGH) ? {26'h0, prio_high_ff}
      : addr_is(ra, IDX_EDGE_SEL)  ? {18'h0, edge_sel_ff}
      : addr_is(ra, IDX_STATUS)    ? {18'h0, status_ff}
      : addr_is(ra, IDX_MASK)      ? {18'h0, mask_ff}
      : addr_is(ra, IDX_PENDING)   ? {18'h0, pend.pending}
      : addr_is(ra, IDX_STATE)     ? {20'h0, in_service_ff, cur_src_ff, 2'h0, state_ff}
      :                              32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // request sensing and arbitration

   irq_source_sense u_sense (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_req     (i_irq_req),
      .pend      (pend.sense)
   );

   wire logic [13:0] en_all  = {en2_ff, en1_ff, en0_ff};
   wire logic [13:0] arb_req = pend.pending & en_all & {NUM_SRC{ge_ff}};
   wire logic        arb_valid;
   wire logic [3:0]  arb_src;
   wire logic [1:0]  arb_lvl;

   irq_arbiter u_arb (
      .i_req       (arb_req),
      .i_prio_low  (prio_low_ff),
      .i_prio_high (prio_high_ff),
      .o_valid     (arb_valid),
      .o_src       (arb_src),
      .o_level     (arb_lvl)
   );

   wire logic [3:0] svc_top     = top_bit(in_service_ff);
   wire logic [3:0] arb_onehot  = 4'(1 << arb_lvl);
   // a request at or below the running level waits for the return
   wire logic       can_preempt = (in_service_ff == 4'h0) | (arb_onehot > svc_top);

   wire logic accept     = (state_ff == ST_CALL) & i_call_ack;
   wire logic accept_src = accept & ~cur_rst_ff;
   wire logic [13:0] cur_onehot = 14'(1 << cur_src_ff);
   wire logic [15:0] vec_calc = cur_rst_ff ? VEC_RESET
                              : VEC_BASE + {9'h0, cur_src_ff, 3'h0};

   assign pend.clear    = accept_src ? cur_onehot : SRC14_RST;
   assign pend.edge_sel = edge_sel_ff;

   wire logic [3:0] push_mask = accept_src ? 4'(1 << cur_lvl_ff) : 4'h0;
   wire logic [3:0] pop_mask  = i_return_from_isr ? svc_top : 4'h0;
   wire logic [3:0] nxt_in_service = (in_service_ff & ~pop_mask) | push_mask;
   wire logic [13:0] status_set = accept_src ? cur_onehot : SRC14_RST;
   // an event in the cycle of the clearing read is kept
   wire logic [13:0] nxt_status = (status_ff & ~{NUM_SRC{status_rd_clr}}) | status_set;
   wire logic nxt_ge = accept ? 1'b0
                     : i_return_from_isr ? 1'b1
                     : wr_en0 ? w_data_ff[GE_BIT] : ge_ff;
   wire logic rst_rise = rst_sync_ff & ~rst_prev_ff;
   wire logic nxt_rst_pend = rst_rise | (rst_pend_ff & ~(accept & cur_rst_ff));

   ////////////////////////////////////////////////////////////////////////////////
   // vectoring sequence

   always_comb begin
      nxt_state    = state_ff;
      nxt_wait_cnt = wait_cnt_ff;
      nxt_cur_src  = cur_src_ff;
      nxt_cur_lvl  = cur_lvl_ff;
      nxt_cur_rst  = cur_rst_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (rst_pend_ff) begin
               nxt_state    = ST_WAIT;
               nxt_cur_rst  = 1'b1;
               nxt_wait_cnt = WAIT_LOAD;
            end else if (arb_valid && can_preempt) begin
               nxt_state    = ST_WAIT;
               nxt_cur_rst  = 1'b0;
               nxt_cur_src  = arb_src;
               nxt_cur_lvl  = arb_lvl;
               nxt_wait_cnt = WAIT_LOAD;
            end
         end
         ST_WAIT: begin
            // pads the path so the call lands no sooner than three machine cycles
            if (wait_cnt_ff == 3'h0) begin
               nxt_state = ST_CALL;
            end else begin
               nxt_wait_cnt = wait_cnt_ff - 3'h1;
            end
         end
         ST_CALL: begin
            if (i_call_ack) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         state_ff      <= ST_IDLE;
         wait_cnt_ff   <= 3'h0;
         cur_src_ff    <= 4'h0;
         cur_lvl_ff    <= 2'h0;
         cur_rst_ff    <= 1'b0;
         in_service_ff <= 4'h0;
         call_ff       <= 1'b0;
         vector_ff     <= VEC_RESET;
         rst_meta_ff   <= 1'b0;
         rst_sync_ff   <= 1'b0;
         rst_prev_ff   <= 1'b0;
         rst_pend_ff   <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         wait_cnt_ff   <= nxt_wait_cnt;
         cur_src_ff    <= nxt_cur_src;
         cur_lvl_ff    <= nxt_cur_lvl;
         cur_rst_ff    <= nxt_cur_rst;
         in_service_ff <= nxt_in_service;
         call_ff       <= (nxt_state == ST_CALL);
         vector_ff     <= vec_calc;
         rst_meta_ff   <= i_hw_reset_source;
         rst_sync_ff   <= rst_meta_ff;
         rst_prev_ff   <= rst_sync_ff;
         rst_pend_ff   <= nxt_rst_pend;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         ge_ff        <= GE_RST;
         en0_ff       <= EN0_RST;
         en1_ff       <= EN1_RST;
         en2_ff       <= EN2_RST;
         prio_low_ff  <= PRIO_RST;
         prio_high_ff <= PRIO_RST;
         edge_sel_ff  <= SRC14_RST;
         mask_ff      <= SRC14_RST;
         status_ff    <= SRC14_RST;
         irq_ff       <= 1'b0;
      end else begin
         ge_ff     <= nxt_ge;
         status_ff <= nxt_status;
         irq_ff    <= |(nxt_status & mask_ff);
         if (wr_en0) en0_ff <= w_data_ff[5:0];
         if (wr_en1) en1_ff <= w_data_ff[5:0];
         if (wr_en2) en2_ff <= w_data_ff[1:0];
         if (wr_plow) prio_low_ff <= w_data_ff[5:0];
         if (wr_phigh) prio_high_ff <= w_data_ff[5:0];
         if (wr_edge) edge_sel_ff <= merge14(edge_sel_ff, w_data_ff, w_strb_ff);
         if (wr_mask) mask_ff <= merge14(mask_ff, w_data_ff, w_strb_ff);
      end
   end

   // address and data are held apart so either may arrive first
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         aw_full_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_full_ff  <= 1'b0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end else begin
         awready_ff <= ~(aw_full_ff | aw_take) | wr_fire;
         wready_ff  <= ~(w_full_ff | w_take) | wr_fire;
         if (aw_take) begin
            aw_full_ff <= 1'b1;
            aw_addr_ff <= i_s_axi_awaddr;
         end else if (wr_fire) begin
            aw_full_ff <= 1'b0;
         end
         if (w_take) begin
            w_full_ff <= 1'b1;
            w_data_ff <= i_s_axi_wdata;
            w_strb_ff <= i_s_axi_wstrb;
         end else if (wr_fire) begin
            w_full_ff <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= ~(rvalid_ff | ar_take) | r_done;
         if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_data;
            rresp_ff  <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (r_done) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_long_call         = call_ff;
   assign o_vector_addr       = vector_ff;
   assign o_global_irq_enable = ge_ff;
   assign o_s_axi_awready     = awready_ff;
   assign o_s_axi_wready      = wready_ff;
   assign o_s_axi_bvalid      = bvalid_ff;
   assign o_s_axi_bresp       = bresp_ff;
   assign o_s_axi_arready     = arready_ff;
   assign o_s_axi_rvalid      = rvalid_ff;
   assign o_s_axi_rdata       = rdata_ff;
   assign o_s_axi_rresp       = rresp_ff;
   assign o_irq               = irq_ff;

endmodule

// *** shared/irq_unit_pkg.sv ***
// constants, register indices and types shared by the vectored interrupt unit
package irq_unit_pkg;

   // source counts and grouping
   localparam int NUM_SRC = 14;
   localparam int NUM_GRP = 6;
   localparam int NUM_LVL = 4;

   // register indices; the bus byte address is four times the index
   localparam logic [7:0] IDX_EN0       = 8'hA8;
   localparam logic [7:0] IDX_EN1       = 8'hA9;
   localparam logic [7:0] IDX_EN2       = 8'hAA;
   localparam logic [7:0] IDX_PRIO_LOW  = 8'hB8;
   localparam logic [7:0] IDX_PRIO_HIGH = 8'hF8;
   localparam logic [7:0] IDX_EDGE_SEL  = 8'h01;
   localparam logic [7:0] IDX_STATUS    = 8'h02;
   localparam logic [7:0] IDX_MASK      = 8'h03;
   localparam logic [7:0] IDX_PENDING   = 8'h04;
   localparam logic [7:0] IDX_STATE     = 8'h05;

   // field positions and reset values
   localparam int          GE_BIT     = 7;
   localparam logic [5:0]  EN0_RST    = 6'h00;
   localparam logic [5:0]  EN1_RST    = 6'h00;
   localparam logic [1:0]  EN2_RST    = 2'h0;
   localparam logic        GE_RST     = 1'h0;
   localparam logic [5:0]  PRIO_RST   = 6'h00;
   localparam logic [13:0] SRC14_RST  = 14'h0000;

   // vector addresses
   localparam logic [15:0] VEC_RESET  = 16'h0000;
   localparam logic [15:0] VEC_BASE   = 16'h0003;

   // latency: machine cycles of two clocks at 25 MHz
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_PER_MC    = 2;
   localparam int LAT_MIN_MC    = 3;
   localparam int LAT_MAX_MC    = 9;
   localparam int LAT_MIN_CLK   = LAT_MIN_MC * CLK_PER_MC;
   localparam int PIPE_CLK      = 4;
   localparam logic [2:0] WAIT_LOAD = 3'(LAT_MIN_CLK - PIPE_CLK - 1);

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CALL} vec_state_type;

endpackage

// *** shared/irq_pend_if.sv ***
// pending flags, their clears and the sense mode between control and sense logic
`timescale 1ns/1ps
interface irq_pend_if;
   import irq_unit_pkg::*;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] clear;
   logic [NUM_SRC-1:0] edge_sel;
   modport sense (output pending, input clear, input edge_sel);
   modport ctl   (input pending, output clear, output edge_sel);
endinterface

// *** logic/irq_source_sense.sv ***
// request synchronisers and per-source pending flags
`timescale 1ns/1ps
module irq_source_sense
   import irq_unit_pkg::*;
(
   // clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rstn,
   // request pins
   input  wire logic [NUM_SRC-1:0] i_req,
   // pending flags
   irq_pend_if.sense               pend
);

   logic [NUM_SRC-1:0] meta_ff;
   logic [NUM_SRC-1:0] sync_ff;
   logic [NUM_SRC-1:0] prev_ff;
   logic [NUM_SRC-1:0] pend_ff;
   logic [NUM_SRC-1:0] nxt_pend;

   genvar k;
   generate
      for (k = 0; k < NUM_SRC; k++) begin : g_src
         // level mode re-arms while the line stays high; a set beats the clear
         wire logic set_k = pend.edge_sel[k] ? (sync_ff[k] & ~prev_ff[k]) : sync_ff[k];
         assign nxt_pend[k] = set_k | (pend_ff[k] & ~pend.clear[k]);
      end
   endgenerate

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         meta_ff <= SRC14_RST;
         sync_ff <= SRC14_RST;
         prev_ff <= SRC14_RST;
         pend_ff <= SRC14_RST;
      end else begin
         meta_ff <= i_req;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         pend_ff <= nxt_pend;
      end
   end

   assign pend.pending = pend_ff;

endmodule

// *** logic/irq_arbiter.sv ***
// picks the highest-level, lowest-numbered eligible request
`timescale 1ns/1ps
module irq_arbiter
   import irq_unit_pkg::*;
(
   // eligible requests and priority bits
   input  wire logic [NUM_SRC-1:0] i_req,
   input  wire logic [NUM_GRP-1:0] i_prio_low,
   input  wire logic [NUM_GRP-1:0] i_prio_high,
   // winner
   output logic                    o_valid,
   output logic [3:0]              o_src,
   output logic [1:0]              o_level
);

   // sources n, n+6, n+12 share group n and its priority bits
   function automatic logic [1:0] level_of(input int src);
      int grp;
      grp = src % NUM_GRP;
      return {i_prio_high[grp], i_prio_low[grp]};
   endfunction

   // later hits overwrite: levels rise outward, numbers fall inward
   always_comb begin
      o_valid = 1'b0;
      o_src   = 4'h0;
      o_level = 2'h0;
      for (int l = 0; l < NUM_LVL; l++) begin
         for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (i_req[k] && (level_of(k) == 2'(l))) begin
               o_valid = 1'b1;
               o_src   = 4'(k);
               o_level = 2'(l);
            end
         end
      end
   end

endmodule

// *** dv/irq_cpu_model.sv ***
// cpu partner: accepts each offered call, then returns from the routine
`timescale 1ns/1ps
module irq_cpu_model (
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   input  wire logic i_long_call,
   input  wire logic i_slow,
   output logic      o_ack,
   output logic      o_ret
);
   initial begin
      o_ack = 1'b0;
      o_ret = 1'b0;
      forever begin
         @(posedge i_ref_clk);
         if (i_long_call && i_rstn) begin
            // slow mode stalls the accept so the offer must hold
            repeat (i_slow ? 5 : 0) @(posedge i_ref_clk);
            o_ack <= 1'b1;
            @(posedge i_ref_clk);
            o_ack <= 1'b0;
            repeat (4) @(posedge i_ref_clk);
            o_ret <= 1'b1;
            @(posedge i_ref_clk);
            o_ret <= 1'b0;
         end
      end
   end
endmodule

// *** dv/irq_unit_monitor.sv ***
// port assertions for the vectored interrupt unit
`timescale 1ns/1ps
module irq_unit_monitor
   import irq_unit_pkg::*;
(
   // clock, reset and cpu side
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_call_ack,
   input  wire logic        i_return_from_isr,
   input  wire logic        o_long_call,
   input  wire logic        o_global_irq_enable,
   input  wire logic [15:0] o_vector_addr,
   // register bus
   input  wire logic        i_s_axi_arvalid,
   input  wire logic        o_s_axi_arready,
   input  wire logic        o_s_axi_rvalid,
   input  wire logic        o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   input  wire logic [1:0]  o_s_axi_bresp
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_take;
      o_long_call && i_call_ack;
   endsequence
   a_offer_holds: assert property (o_long_call && !i_call_ack |=>
      o_long_call && $stable(o_vector_addr)) else $error("offer changed before accept");
   a_take_clears: assert property (s_take |=> !o_long_call && !o_global_irq_enable)
      else $error("accept did not clear global enable");
   a_return_enables: assert property (i_return_from_isr && !o_long_call |=>
      o_global_irq_enable) else $error("return did not set global enable");
   a_vector_form: assert property (o_long_call |-> o_vector_addr == VEC_RESET ||
      (o_vector_addr[2:0] == 3'h3 && o_vector_addr <= 16'h006B)) else $error("bad vector");
   a_drop_on_take: assert property ($fell(o_long_call) |-> $past(i_call_ack))
      else $error("offer withdrawn without accept");
   a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
      o_s_axi_rvalid && !o_s_axi_arready) else $error("read answer late");
   a_resp_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
      o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
   a_read_single: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("second read accepted");
endmodule
bind prioritised_vectored_interrupt_unit irq_unit_monitor mon_u (.*);

// *** dv/prioritised_vectored_interrupt_unit_bench.sv ***
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
module prioritised_vectored_interrupt_unit_bench
   import irq_unit_pkg::*;
;
   logic        i_ref_clk, i_rstn, i_hw_reset_source, i_call_ack, i_return_from_isr, slow;
   logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
   logic        o_long_call, o_global_irq_enable, o_s_axi_awready, o_s_axi_wready, o_irq;
   logic        o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [13:0] i_irq_req;
   logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic [3:0]  i_s_axi_wstrb;
   logic [15:0] o_vector_addr;
   logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
   logic [33:0] rq[$];
   logic [15:0] vq[$];
   logic [7:0]  rst_idx [6] = '{IDX_EN0, IDX_EN1, IDX_EN2, IDX_PRIO_LOW, IDX_PRIO_HIGH, IDX_STATUS};
   int          miscompares = 0, n_tests = 0, seed = 78334, k;
   prioritised_vectored_interrupt_unit dut_u (.*);
   irq_cpu_model cpu_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_long_call(o_long_call),
      .i_slow(slow), .o_ack(i_call_ack), .o_ret(i_return_from_isr));
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   function logic [15:0] vec(input int s);
      return VEC_BASE + 16'(8 * s);
   endfunction
   task chk(input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      rq.push_back({r, 32'h0});
      @(posedge i_ref_clk);
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid  <= 1'b1;
      i_s_axi_awaddr  <= {2'h0, idx, 2'h0};
      i_s_axi_wdata   <= d;
      i_s_axi_bready  <= 1'b1;
      // each channel is let go only at the edge that takes it
      do begin
         @(posedge i_ref_clk);
         if (o_s_axi_awready) aw_done = 1'b1;
         if (o_s_axi_wready) w_done = 1'b1;
         if (aw_done) i_s_axi_awvalid <= 1'b0;
         if (w_done) i_s_axi_wvalid <= 1'b0;
      end while (!(aw_done && w_done));
      do @(posedge i_ref_clk); while (o_s_axi_bvalid !== 1'b1);
      i_s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] idx, input logic [33:0] exp);
      rq.push_back(exp);
      @(posedge i_ref_clk);
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_araddr  <= {2'h0, idx, 2'h0};
      do @(posedge i_ref_clk); while (o_s_axi_arready !== 1'b1);
      i_s_axi_arvalid <= 1'b0;
      i_s_axi_rready  <= 1'b1;
      do @(posedge i_ref_clk); while (o_s_axi_rvalid !== 1'b1);
      i_s_axi_rready <= 1'b0;
   endtask
   task pulse(input logic [13:0] m);
      @(posedge i_ref_clk);
      i_irq_req <= m;
      repeat (2) @(posedge i_ref_clk);
      i_irq_req <= 14'h0000;
   endtask
   // waits for every noted vector, then for the routine's return
   task drain;
      for (int t = 0; t < 400 && vq.size() > 0; t++) @(posedge i_ref_clk);
      repeat (12) @(posedge i_ref_clk);
      chk(34'(vq.size()), 34'h0);
   endtask
   always @(posedge i_ref_clk) begin
      if (o_s_axi_rvalid && i_s_axi_rready)
         chk({o_s_axi_rresp, o_s_axi_rdata},
             (rq.size() > 0) ? rq.pop_front() : 34'bx);
      if (o_s_axi_bvalid && i_s_axi_bready)
         chk({o_s_axi_bresp, 32'h0},
             (rq.size() > 0) ? rq.pop_front() : 34'bx);
      if (o_long_call && i_call_ack)
         chk(34'(o_vector_addr),
             (vq.size() > 0) ? 34'(vq.pop_front()) : 34'bx);
   end
   initial begin
      #3000000;
      miscompares++;
      give_verdict;
   end
   initial begin
      {i_rstn, i_hw_reset_source, slow, i_s_axi_awvalid, i_s_axi_wvalid} = '0;
      {i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready, i_irq_req} = '0;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
      i_s_axi_wstrb = 4'hF;
      repeat (5) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      foreach (rst_idx[i]) rd(rst_idx[i], 34'h0);
      rd(8'h10, {RESP_SLVERR, 32'h0});
      wr(8'h10, 32'h1, RESP_SLVERR);
      // source 0 stays level-sensed so both sensing modes are exercised
      wr(IDX_EDGE_SEL, 32'h3FFE);
      wr(IDX_MASK, 32'h3FFF);
      wr(IDX_EN1, 32'h3F);
      wr(IDX_EN2, 32'h3);
      wr(IDX_EN0, 32'hBF);
      rd(IDX_EN0, 34'hBF);
      for (k = 0; k < 14; k++) begin
         slow <= k[0];
         vq.push_back(vec(k));
         pulse(14'h0001 << k);
         drain;
      end
      repeat (4) begin
         k = {$random(seed)} % 14;
         vq.push_back(vec(k));
         pulse(14'h0001 << k);
         drain;
      end
      chk(34'(o_irq), 34'h1);
      rd(IDX_STATUS, 34'h3FFF);
      chk(34'(o_irq), 34'h0);
      vq.push_back(vec(2));
      vq.push_back(vec(8));
      pulse(14'h0104);
      drain;
      wr(IDX_PRIO_HIGH, 32'h08);
      vq.push_back(vec(9));
      vq.push_back(vec(1));
      pulse(14'h0202);
      drain;
      wr(IDX_EN0, 32'h3F);
      vq.push_back(vec(2));
      pulse(14'h0004);
      repeat (40) @(posedge i_ref_clk);
      chk(34'(vq.size()), 34'h1);
      vq.push_front(VEC_RESET);
      i_hw_reset_source <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_hw_reset_source <= 1'b0;
      drain;
      chk(34'(o_global_irq_enable), 34'h1);
      give_verdict;
   end
endmodule
